/* File: logic/dim_pkg.sv */
// Constants and types shared by the dimming and fault controller
package dim_pkg;
  // Frame layout: write flag, 7-bit address, 8-bit data
  localparam logic [4:0] FRAME_LEN = 5'h10;
  localparam logic [4:0] LAST_BIT  = 5'h0f;
  localparam int         WR_BIT    = 15;
  // Register addresses
  localparam logic [6:0] A_CFG    = 7'h00;
  localparam logic [6:0] A_EN     = 7'h01;
  localparam logic [6:0] A_ADJ    = 7'h02;
  localparam logic [6:0] A_CH     = 7'h04;
  localparam logic [6:0] A_LH_ADJ = 7'h10;
  localparam logic [6:0] A_LH_CH  = 7'h14;
  localparam logic [6:0] A_FLT    = 7'h20;
  localparam logic [6:0] A_GFLT   = 7'h22;
  // Offsets inside a channel block
  localparam logic [1:0] O_WID = 2'h0;
  localparam logic [1:0] O_PER = 2'h1;
  localparam logic [1:0] O_HI  = 2'h2;
  localparam logic [1:0] O_TMR = 2'h3;
  // Configuration bit positions
  localparam int B_LH   = 0;
  localparam int B_2PH  = 1;
  localparam int B_CV   = 2;
  localparam int B_EXT  = 4;
  localparam int B_AUTO = 6;
  // Channel fault bits
  localparam int F_ILIM = 0;
  localparam int F_OV   = 1;
  localparam int F_UV   = 2;
  localparam int F_OC   = 3;
  localparam int F_UC   = 4;
  localparam int F_FBO  = 5;
  localparam int F_ISO  = 6;
  localparam logic [6:0] PROT_MASK = 7'h0f;
  // Global fault bits
  localparam int G_TSD = 0;
  localparam int G_TW  = 1;
  localparam int G_RTO = 2;
  localparam int G_POR = 3;
  localparam logic [3:0] G_RESET = 4'h8;
  // Synchronised input vector layout
  localparam int P_CH  = 7;
  localparam int P_G   = 14;
  localparam int P_DIM = 18;
  localparam int P_LH  = 20;
  localparam int IN_W  = 21;
  // Timing
  localparam int CLK_NS          = 100;
  localparam int SW_PERIOD_NS    = 2500;
  localparam int RESTART_UNIT_NS = 100000;
  localparam int SW_CYC          = SW_PERIOD_NS / CLK_NS;
  localparam logic [4:0] SW_LAST = 5'(SW_CYC - 1);
  localparam logic [4:0] SW_HALF = 5'(SW_CYC / 2);
  localparam int RESTART_TICKS   = (RESTART_UNIT_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [9:0] TICK_LAST = 10'(RESTART_TICKS - 1);
  typedef enum logic [1:0] {
    CH_RUN   = 2'b00,
    CH_LATCH = 2'b01,
    CH_WAIT  = 2'b10
  } ch_state_e;
endpackage

/* File: logic/spi_link.sv */
// Serial frame shifter running on the host's serial clock
`timescale 1ns/1ps
`default_nettype none
module spi_link
  import dim_pkg::*;
(
  input  wire logic        rst_in,
  input  wire logic        sck_in,
  input  wire logic        chip_select_n_in,
  input  wire logic        mosi_in,
  input  wire logic [14:0] rd_word_in,
  output logic [15:0]      frame_word_out,
  output logic             frame_toggle_out,
  output logic             miso_out,
  output logic             miso_oe_out
);
  typedef struct packed {
    logic [4:0]  cnt;
    logic [14:0] shift;
    logic [14:0] tx;
  } bit_s;
  typedef struct packed {
    logic [15:0] word;
    logic        tgl;
  } frame_s;
  bit_s   b;
  bit_s   next_b;
  frame_s f;
  frame_s next_f;
  logic   clr;

  // Bit state is held clear while select is high
  assign clr = rst_in | chip_select_n_in;

  // Rising edge shifts data in, reply loads on first bit
  always_comb begin
    next_b = b;
    next_f = f;
    if (b.cnt != FRAME_LEN) begin
      next_b.cnt = b.cnt + 5'h01;
    end
    next_b.shift = {b.shift[13:0], mosi_in};
    next_b.tx = (b.cnt == 5'h00) ? rd_word_in : {b.tx[13:0], 1'b0};
    if (b.cnt == LAST_BIT) begin
      next_f.word = {b.shift, mosi_in};
      next_f.tgl  = ~f.tgl;
    end
  end

  // Bit counter and shifters
  always_ff @(posedge sck_in or posedge clr) begin
    if (clr) begin
      b <= '0;
    end else begin
      b <= next_b;
    end
  end

  // Finished frame survives select going high
  always_ff @(posedge sck_in or posedge rst_in) begin
    if (rst_in) begin
      f <= '0;
    end else begin
      f <= next_f;
    end
  end

  // Reply changes after the falling edge, released with select high
  always_ff @(negedge sck_in or posedge clr) begin
    if (clr) begin
      miso_out    <= 1'b0;
      miso_oe_out <= 1'b0;
    end else begin
      miso_out    <= b.tx[14];
      miso_oe_out <= 1'b1;
    end
  end

  assign frame_word_out   = f.word;
  assign frame_toggle_out = f.tgl;

  frame_take_a: assert property (@(negedge sck_in) disable iff (clr)
    b.cnt == FRAME_LEN && $past(b.cnt) == LAST_BIT |-> f.tgl != $past(f.tgl))
    else $error("frame not taken at last bit");
  reply_load_a: assert property (@(posedge sck_in) disable iff (clr)
    b.cnt == 5'h00 |=> b.tx == $past(rd_word_in)) else $error("reply word not loaded");
endmodule // spi_link
`default_nettype wire

/* File: logic/dim_fault_ctrl.sv */
// Two-channel dimming, mode, limp-home and fault control with serial access
`timescale 1ns/1ps
`default_nettype none
module dim_fault_ctrl
  import dim_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        sck_in,
  input  wire logic        chip_select_n_in,
  input  wire logic        mosi_in,
  output logic             miso_out,
  output logic             miso_oe_out,
  input  wire logic        dimming_input_one_in,
  input  wire logic        dimming_input_two_in,
  input  wire logic        limp_home_in,
  input  wire logic [6:0]  ch1_fault_in,
  input  wire logic [6:0]  ch2_fault_in,
  input  wire logic [3:0]  global_fault_in,
  output logic [1:0]       switch_gate_out,
  output logic [1:0]       series_fet_drive_out,
  output logic [1:0]       fault_flag_n_out,
  output logic [1:0]       cv_mode_out,
  output logic [15:0]      voltage_ref_out,
  output logic [15:0]      current_ref_out,
  output logic             shared_compensation_node_out,
  output logic             limp_home_active_out
);
  typedef struct packed {
    logic [IN_W-1:0]  in1;
    logic [IN_W-1:0]  in2;
    logic [2:0]       tsync;
    logic [31:0][7:0] regs;
    logic [14:0]      rd_hold;
    logic [1:0][6:0]  fault_flag_n;
    logic [3:0]       gflt;
    logic [9:0]       pre;
    logic [4:0]       swc;
    logic [1:0][9:0]  dcnt;
    ch_state_e [1:0]  st;
    logic [1:0][7:0]  tmr;
    logic [1:0]       gate;
    logic [1:0]       pdrv;
    logic [1:0]       fltn;
    logic [1:0]       cv;
    logic [15:0]      vref;
    logic [15:0]      iref;
    logic             comp;
  } state_s;

  state_s      s;
  state_s      next_s;
  logic [15:0] frame_word;
  logic        frame_toggle;
  logic        ev;
  logic        wr;
  logic [6:0]  ad;
  logic        tick;
  logic [1:0]  prot;
  logic [9:0]  per_one;
  logic [IN_W-1:0] raw;

  // Serial link on the host clock
  spi_link link (
    .rst_in           (rst_in),
    .sck_in           (sck_in),
    .chip_select_n_in (chip_select_n_in),
    .mosi_in          (mosi_in),
    .rd_word_in       (s.rd_hold),
    .frame_word_out   (frame_word),
    .frame_toggle_out (frame_toggle),
    .miso_out         (miso_out),
    .miso_oe_out      (miso_oe_out)
  );

  // Pin inputs gathered for synchronising
  assign raw = {limp_home_in, dimming_input_two_in, dimming_input_one_in,
                global_fault_in, ch2_fault_in, ch1_fault_in};

  // Frame arrival and decode; the word itself is not resynchronised,
  // the select high time between frames keeps it still when the toggle lands
  assign ev   = s.tsync[1] ^ s.tsync[2];
  assign wr   = ev && frame_word[WR_BIT];
  assign ad   = frame_word[14:8];
  assign tick = s.pre == TICK_LAST;
  assign prot = {|(s.in2[P_CH +: P_CH] & PROT_MASK), |(s.in2[0 +: P_CH] & PROT_MASK)};
  // Channel one normal period, watched by the counter checks
  assign per_one = {s.regs[A_CH[4:0] + {3'h0, O_HI}][3:2], s.regs[A_CH[4:0] + {3'h0, O_PER}]};

  // Next state of the whole controller
  always_comb begin
    logic [4:0] b;
    logic [4:0] ai;
    logic [9:0] wid;
    logic [9:0] per;
    logic [7:0] adj;
    logic [7:0] rv;
    logic       lh;
    logic       cv;
    logic       ext;
    logic       dim;
    logic       on;
    logic       ph1;
    logic       ph;
    b   = '0;
    ai  = '0;
    wid = '0;
    per = '0;
    adj = '0;
    rv  = '0;
    lh  = 1'b0;
    cv  = 1'b0;
    ext = 1'b0;
    dim = 1'b0;
    on  = 1'b0;
    ph1 = 1'b0;
    ph  = 1'b0;
    next_s = s;
    // Two-flop synchronisers and frame toggle detect
    next_s.in1   = raw;
    next_s.in2   = s.in1;
    next_s.tsync = {s.tsync[1:0], frame_toggle};
    // Restart timer prescale and switching cycle counter
    next_s.pre = tick ? 10'h000 : s.pre + 10'h001;
    next_s.swc = (s.swc == SW_LAST) ? 5'h00 : s.swc + 5'h01;
    // Register writes from a finished frame only
    if (wr && ad < A_FLT) begin
      next_s.regs[ad[4:0]] = frame_word[7:0];
    end
    // Pin high sets limp-home bit and wins over a write of zero
    next_s.regs[A_CFG[4:0]][B_LH] = next_s.regs[A_CFG[4:0]][B_LH] | s.in2[P_LH];
    // Sticky global faults, cleared by writing ones, set wins
    next_s.gflt = s.gflt;
    if (wr && ad == A_GFLT) begin
      next_s.gflt = s.gflt & ~frame_word[3:0];
    end
    next_s.gflt = next_s.gflt | s.in2[P_G +: 4];
    // Read reply prepared for the next frame
    ai = ad[4:0];
    if (ad < A_FLT) begin
      rv = s.regs[ai];
    end else if (ad == A_FLT) begin
      rv = {1'b0, s.fault_flag_n[0]};
    end else if (ad == A_FLT + 7'h01) begin
      rv = {1'b0, s.fault_flag_n[1]};
    end else if (ad == A_GFLT) begin
      rv = {4'h0, s.gflt};
    end
    if (ev) begin
      next_s.rd_hold = {ad, rv};
    end
    lh  = s.regs[A_CFG[4:0]][B_LH];
    ph1 = s.swc < SW_HALF;
    next_s.comp = s.regs[A_CFG[4:0]][B_2PH];
    for (int c = 0; c < 2; c++) begin
      // Limp-home set relies on host programming it at start-up
      b   = lh ? A_LH_CH[4:0] : A_CH[4:0];
      b   = b + {2'h0, c[0], 2'h0};
      wid = {s.regs[b + {3'h0, O_HI}][1:0], s.regs[b + {3'h0, O_WID}]};
      per = {s.regs[b + {3'h0, O_HI}][3:2], s.regs[b + {3'h0, O_PER}]};
      adj = s.regs[(lh ? A_LH_ADJ[4:0] : A_ADJ[4:0]) + {4'h0, c[0]}];
      cv  = s.regs[A_CFG[4:0]][B_CV + c];
      ext = s.regs[A_CFG[4:0]][B_EXT + c];
      // Channel fault status, set wins over clear
      if (wr && ad == A_FLT + {6'h00, c[0]}) begin
        next_s.fault_flag_n[c] = s.fault_flag_n[c] & ~frame_word[6:0];
      end
      next_s.fault_flag_n[c] = next_s.fault_flag_n[c] | s.in2[P_CH * c +: P_CH];
      // Internal 10-bit dimming counter
      next_s.dcnt[c] = (s.dcnt[c] >= per) ? 10'h000 : s.dcnt[c] + 10'h001;
      dim = ext ? s.in2[P_DIM + c] : (s.dcnt[c] < wid);
      // Latch or auto-restart handling
      unique case (s.st[c])
        CH_RUN: begin
          if (prot[c]) begin
            next_s.st[c]  = s.regs[A_CFG[4:0]][B_AUTO + c] ? CH_WAIT : CH_LATCH;
            next_s.tmr[c] = s.regs[b + {3'h0, O_TMR}];
          end
        end
        CH_LATCH: begin
          if (!s.regs[A_EN[4:0]][c]) begin
            next_s.st[c] = CH_RUN;
          end
        end
        CH_WAIT: begin
          if (prot[c]) begin
            next_s.tmr[c] = s.regs[b + {3'h0, O_TMR}];
          end else if (tick) begin
            if (s.tmr[c] == 8'h00) begin
              next_s.st[c] = CH_RUN;
            end else begin
              next_s.tmr[c] = s.tmr[c] - 8'h01;
            end
          end
        end
        default: begin
          next_s.st[c] = CH_LATCH;
        end
      endcase
      on = s.regs[A_EN[4:0]][c] && s.st[c] == CH_RUN && !prot[c] && !s.in2[P_G + G_TSD];
      // Channel two runs half a cycle later in two-phase mode
      ph = (c == 1 && s.regs[A_CFG[4:0]][B_2PH]) ? !ph1 : ph1;
      next_s.gate[c] = on && dim && ph;
      next_s.pdrv[c] = on && dim;
      next_s.fltn[c] = !((|s.fault_flag_n[c]) || (|s.gflt));
      next_s.cv[c]   = cv;
      next_s.vref[8 * c +: 8] = cv ? adj : 8'h00;
      next_s.iref[8 * c +: 8] = cv ? 8'h00 : adj;
    end
  end

  // Single state register
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s      <= '0;
      s.gflt <= G_RESET;
      s.fltn <= 2'h0;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from the state register
  assign switch_gate_out              = s.gate;
  assign series_fet_drive_out         = s.pdrv;
  assign fault_flag_n_out             = s.fltn;
  assign cv_mode_out                  = s.cv;
  assign voltage_ref_out              = s.vref;
  assign current_ref_out              = s.iref;
  assign shared_compensation_node_out = s.comp;
  assign limp_home_active_out         = s.regs[A_CFG[4:0]][B_LH];

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  // Steps of a fault trip and of the restart
  sequence trip_latch_s;
    s.st[0] == CH_RUN && prot[0] && !s.regs[A_CFG[4:0]][B_AUTO];
  endsequence
  sequence wait_done_s;
    s.st[0] == CH_WAIT && !prot[0] && tick && s.tmr[0] == 8'h00;
  endsequence
  sequence trip_wait_s;
    s.st[0] == CH_RUN && prot[0] && s.regs[A_CFG[4:0]][B_AUTO];
  endsequence

  // Output relations and latching
  gate_needs_dim_a: assert property (
    switch_gate_out[0] |-> series_fet_drive_out[0]) else $error("gate without series drive");
  phase_split_a: assert property (
    shared_compensation_node_out |-> !(switch_gate_out[0] && switch_gate_out[1]))
    else $error("both phases on together");
  latch_off_a: assert property (
    trip_latch_s |=> s.st[0] == CH_LATCH ##1 !switch_gate_out[0]) else $error("fault did not latch");
  restart_a: assert property (
    wait_done_s |=> s.st[0] == CH_RUN) else $error("restart not taken");
  flag_low_a: assert property (
    s.fault_flag_n[0] != 7'h00 |=> !fault_flag_n_out[0]) else $error("fault flag not low");
  status_sets_a: assert property (
    s.in2[F_OV] |=> s.fault_flag_n[0][F_OV]) else $error("status bit not set");
  lh_hold_a: assert property (
    s.in2[P_LH] |=> limp_home_active_out) else $error("limp-home left while pin high");
  cv_ref_a: assert property (
    s.regs[A_CFG[4:0]][B_CV] && !ev |=> voltage_ref_out[7:0] == $past(s.regs[A_ADJ[4:0]]) ||
    limp_home_active_out) else $error("voltage reference not from adjust");
  idle_keep_a: assert property (
    !ev |=> $stable(s.regs[A_EN[4:0]])) else $error("register changed without frame");
  dim_wrap_a: assert property (
    !limp_home_active_out && s.dcnt[0] >= per_one |=> s.dcnt[0] == 10'h000)
    else $error("dimming counter wrap wrong");
  dim_step_a: assert property (
    !limp_home_active_out && s.dcnt[0] < per_one |=> s.dcnt[0] == $past(s.dcnt[0]) + 10'h001)
    else $error("dimming counter step wrong");

  // Fault handling and flags
  wait_trip_a: assert property (
    trip_wait_s |=> s.st[0] == CH_WAIT ##1 !series_fet_drive_out[0]) else $error("restart wait not entered");
  latch_hold_a: assert property (
    s.st[0] == CH_LATCH && s.regs[A_EN[4:0]][0] |=> s.st[0] == CH_LATCH) else $error("latch released early");
  tsd_off_a: assert property (
    s.in2[P_G + G_TSD] |=> series_fet_drive_out == 2'b00 && switch_gate_out == 2'b00)
    else $error("thermal shutdown left a channel on");
  gflt_sets_a: assert property (
    s.in2[P_G + G_TW] |=> s.gflt[G_TW]) else $error("global status bit not set");
  flag_two_a: assert property (
    s.fault_flag_n[1] != 7'h00 |=> !fault_flag_n_out[1]) else $error("channel two flag not low");
  flag_high_a: assert property (
    s.fault_flag_n[0] == 7'h00 && s.gflt == 4'h0 |=> fault_flag_n_out[0]) else $error("fault flag low without fault");

  // Limp-home, external dimming and serial access
  lh_exit_a: assert property (
    limp_home_active_out && !ev |=> limp_home_active_out) else $error("limp-home left without a write");
  ext_follow_a: assert property (
    s.regs[A_CFG[4:0]][B_EXT + 1] && !s.in2[P_DIM + 1] |=> !series_fet_drive_out[1])
    else $error("series drive on with external input low");
  cfg_keep_a: assert property (
    !ev && !s.in2[P_LH] |=> $stable(s.regs[A_CFG[4:0]])) else $error("configuration changed without frame");
  reply_addr_a: assert property (
    ev |=> s.rd_hold[14:8] == $past(ad)) else $error("reply not tagged with frame address");
endmodule // dim_fault_ctrl
`default_nettype wire

/* File: sim/spi_host.sv */
// Host model driving the four-wire serial link as master
`timescale 1ns/1ps
`default_nettype none
module spi_host (
  output logic     sck_out,
  output logic     chip_select_n_out,
  output logic     mosi_out,
  input  wire logic miso_in,
  input  wire logic miso_oe_in
);
  // Idle: select high, clock parked low
  initial begin
    sck_out = 1'b0;
    chip_select_n_out = 1'b1;
    mosi_out = 1'b0;
  end

  // One 16-bit frame, MSB first, reply sampled at rising edges 2..16
  task automatic xfer(input logic [15:0] w, output logic [14:0] r);
    int i;
    r = '0;
    chip_select_n_out = 1'b0;
    #500;
    for (i = 15; i >= 0; i--) begin
      mosi_out = w[i];
      #15;
      if (i < 15) r[i] = miso_oe_in ? miso_in : 1'bx;
      sck_out = 1'b1;
      #15;
      sck_out = 1'b0;
    end
    #250;
    chip_select_n_out = 1'b1;
    mosi_out = ~mosi_out; // Released data line shows no stale value
    #1200;
  endtask

  // Clock and data wiggled while deselected
  task automatic noise();
    int i;
    for (i = 0; i < 16; i++) begin
      mosi_out = ~mosi_out;
      sck_out = 1'b1;
      #15;
      sck_out = 1'b0;
      #15;
    end
  endtask
endmodule // spi_host
`default_nettype wire

/* File: sim/dim_fault_ctrl_test.sv */
// Self-checking bench for the dimming and fault controller
`timescale 1ns/1ps
`default_nettype none
module dim_fault_ctrl_test;
  logic        clk_in, rst_in, sck, cs_n, mosi, miso, miso_oe;
  logic        dim1, dim2, lh;
  logic [6:0]  ch1_f, ch2_f;
  logic [3:0]  gl_f;
  logic [1:0]  gate, sfet, flag_n, cv;
  logic [15:0] vref, iref, s, g;
  logic        shared, lh_act;
  logic [14:0] r;
  int          num_errors, tests_run, cycles, i;

  spi_host host (.sck_out(sck), .chip_select_n_out(cs_n), .mosi_out(mosi), .miso_in(miso), .miso_oe_in(miso_oe));

  dim_fault_ctrl uut (
    .clk_in(clk_in), .rst_in(rst_in), .sck_in(sck), .chip_select_n_in(cs_n), .mosi_in(mosi),
    .miso_out(miso), .miso_oe_out(miso_oe), .dimming_input_one_in(dim1), .dimming_input_two_in(dim2),
    .limp_home_in(lh), .ch1_fault_in(ch1_f), .ch2_fault_in(ch2_f), .global_fault_in(gl_f),
    .switch_gate_out(gate), .series_fet_drive_out(sfet), .fault_flag_n_out(flag_n), .cv_mode_out(cv),
    .voltage_ref_out(vref), .current_ref_out(iref), .shared_compensation_node_out(shared),
    .limp_home_active_out(lh_act)
  );

  // Main clock, 100 ns period
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  // Hang guard
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 12000) begin
      num_errors++;
      $display("CHECK FAILED at %0t: run did not finish", $time);
      test_done();
    end
  end

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host.xfer({1'b1, a, d}, r);
  endtask

  // Reply arrives in the following frame
  task automatic rd(input logic [6:0] a, input logic [7:0] exp, input string msg);
    host.xfer({1'b0, a, 8'h00}, r);
    host.xfer({1'b0, a, 8'h00}, r);
    chk({1'b0, r}, {1'b0, a, exp}, msg);
  endtask

  // Let synchronisers and registered outputs settle
  task automatic settle();
    repeat (6) @(negedge clk_in);
  endtask

  // High cycles of series drive and gate for one channel
  task automatic cnt(input int ch, input int n, output logic [15:0] sc, output logic [15:0] gc);
    sc = '0;
    gc = '0;
    repeat (n) begin
      @(negedge clk_in);
      sc += 16'(sfet[ch]);
      gc += 16'(gate[ch]);
    end
  endtask

  // Test sequence
  initial begin
    rst_in = 1'b1; dim1 = 1'b0; dim2 = 1'b0; lh = 1'b0;
    ch1_f = '0; ch2_f = '0; gl_f = '0;
    repeat (10) @(posedge clk_in);
    chk({12'h0, flag_n, gate}, 16'h0, "reset outputs");
    chk({15'h0, miso_oe}, 16'h0, "reset miso enable");
    rst_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    wr(7'h10, 8'h44);
    rd(7'h22, 8'h08, "power-on status");
    chk({14'h0, flag_n}, 16'h0, "flags while power-on set");
    wr(7'h22, 8'h08);
    chk({14'h0, flag_n}, 16'h3, "flags after clear");
    chk({15'h0, miso_oe}, 16'h0, "miso released");
    // Independent modes and references
    wr(7'h00, 8'h04);
    wr(7'h02, 8'h5a);
    wr(7'h03, 8'h33);
    chk({14'h0, cv}, 16'h1, "mode per channel");
    chk(vref, 16'h005a, "voltage reference");
    chk(iref, 16'h3300, "current reference");
    host.noise();
    rd(7'h00, 8'h04, "deselected activity");
    // Internal dimming, width 3 of a 10-cycle period (period setting 9)
    wr(7'h01, 8'h03);
    wr(7'h04, 8'h03);
    wr(7'h05, 8'h09);
    wr(7'h06, 8'h00);
    cnt(0, 100, s, g);
    chk(s, 16'd30, "internal duty");
    chk({15'h0, g > 0 && g <= s}, 16'h1, "gate within dim");
    wr(7'h06, 8'h01);
    cnt(0, 100, s, g);
    chk(s, 16'd100, "width above period");
    wr(7'h06, 8'h00);
    // External dimming on channel two, two-phase on
    wr(7'h00, 8'h26);
    chk({15'h0, shared}, 16'h1, "two-phase shared loop");
    @(posedge clk_in) dim2 <= 1'b1;
    settle();
    cnt(1, 20, s, g);
    chk(s, 16'd20, "external high");
    @(posedge clk_in) dim2 <= 1'b0;
    settle();
    cnt(1, 20, s, g);
    chk(s, 16'd0, "external low");
    // Latched fault on channel one
    @(posedge clk_in) ch1_f <= 7'h01;
    settle();
    chk({14'h0, flag_n}, 16'h2, "ch1 flag only");
    @(posedge clk_in) ch1_f <= 7'h00;
    settle();
    cnt(0, 30, s, g);
    chk(s, 16'd0, "latched off");
    rd(7'h20, 8'h01, "limit status");
    wr(7'h20, 8'h01);
    wr(7'h01, 8'h02);
    wr(7'h01, 8'h03);
    cnt(0, 100, s, g);
    chk(s, 16'd30, "latch released");
    chk({14'h0, flag_n}, 16'h3, "flags clear");
    // Auto restart, timer 1: second free-running tick, so 1000 to 2000 cycles
    wr(7'h00, 8'h64);
    wr(7'h07, 8'h01);
    @(posedge clk_in) ch1_f <= 7'h02;
    settle();
    @(posedge clk_in) ch1_f <= 7'h00;
    cnt(0, 900, s, g);
    chk(s, 16'd0, "restart wait");
    i = 0;
    while (sfet[0] !== 1'b1 && i < 1300) begin
      @(negedge clk_in);
      i++;
    end
    chk({15'h0, sfet[0]}, 16'h1, "auto restart");
    wr(7'h20, 8'h02);
    // Global warning
    @(posedge clk_in) gl_f <= 4'h2;
    settle();
    chk({14'h0, flag_n}, 16'h0, "warning flags");
    @(posedge clk_in) gl_f <= 4'h0;
    rd(7'h22, 8'h02, "warning status");
    wr(7'h22, 8'h02);
    chk({14'h0, flag_n}, 16'h3, "warning cleared");
    // Thermal shutdown holds channel one off despite its duty
    @(posedge clk_in) gl_f <= 4'h1;
    settle();
    cnt(0, 30, s, g);
    chk(s, 16'd0, "thermal shutdown off");
    @(posedge clk_in) gl_f <= 4'h0;
    wr(7'h22, 8'h01);
    // Limp-home entry and exit
    wr(7'h00, 8'h00);
    @(posedge clk_in) lh <= 1'b1;
    settle();
    chk({15'h0, lh_act}, 16'h1, "limp entry");
    chk(iref, 16'h0044, "limp set used");
    @(posedge clk_in) lh <= 1'b0;
    settle();
    chk({15'h0, lh_act}, 16'h1, "pin low alone");
    wr(7'h00, 8'h00);
    chk({15'h0, lh_act}, 16'h0, "limp exit");
    chk(iref, 16'h335a, "normal set back");
    test_done();
  end
endmodule // dim_fault_ctrl_test
`default_nettype wire
